// ===== src/pfl_pkg.sv
`default_nettype none

package pfl_pkg;

	// ----------------------------------------
	// instruction codes
	// ----------------------------------------
	localparam logic [7:0] CMD_WRITE_ENABLE = 8'h06;
	localparam logic [7:0] CMD_CLEAR_STATUS = 8'h30;
	localparam logic [7:0] CMD_LOCK_READ = 8'hA7;
	localparam logic [7:0] CMD_LOCK_CLEAR = 8'hA6;
	localparam logic [7:0] CMD_PW_READ = 8'hE7;
	localparam logic [7:0] CMD_PW_PROGRAM = 8'hE8;
	localparam logic [7:0] CMD_PW_UNLOCK = 8'hE9;
	localparam logic [7:0] CMD_SOFT_RESET = 8'hF0;
	localparam logic [7:0] CMD_MODE_BIT_RESET = 8'hFF;

	// ----------------------------------------
	// frame lengths in serial clocks
	// ----------------------------------------
	localparam logic [7:0] LEN_INSTR = 8'h08;
	localparam logic [7:0] LEN_INSTR_PW = 8'h48;
	localparam int PW_BYTES = 8;
	localparam int PW_BITS = 64;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int OP_TIME_NS = 2000;
	localparam int RESET_RECOVERY_TIME_NS = 10000;
	localparam int OP_CYCLES_I = (OP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RECOVERY_CYCLES_I =
		(RESET_RECOVERY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [11:0] OP_CYCLES = 12'(OP_CYCLES_I);
	localparam logic [11:0] RECOVERY_CYCLES = 12'(RECOVERY_CYCLES_I);

	// ----------------------------------------
	// configuration bits and status flags
	// ----------------------------------------
	typedef struct packed {
		logic top_bottom_protect;
		logic top_bottom_param;
		logic block_protect_nonvolatile;
		logic freeze;
		logic block_protect_bit2;
		logic block_protect_bit1;
		logic block_protect_bit0;
	} pfl_cfg_type;

	typedef struct packed {
		logic write_in_progress;
		logic write_enable_latch;
		logic program_error;
		logic lock_bit;
	} pfl_status_type;

	localparam pfl_cfg_type CFG_RESET = 7'h00;
	localparam logic [2:0] BP_CLEARED = 3'h0;

	typedef enum {
		OP_LOCK_CLEAR,
		OP_PROGRAM,
		OP_UNLOCK
	} pfl_op_type;

endpackage

`default_nettype wire

// ===== src/pfl_pw_store.sv
`default_nettype none

// ----------------------------------------
// eight-byte password store
// ----------------------------------------
// one write port and one read port on the core clock, one read port on the
// serial clock; both read ports deliver data from a register
module pfl_pw_store (
	// core side
	input wire logic clk,
	input wire logic wr_en,
	input wire logic [2:0] wr_addr,
	input wire logic [7:0] wr_data,
	input wire logic [2:0] rda_addr,
	output logic [7:0] rda_data,
	// serial side
	input wire logic rd_clk,
	input wire logic [2:0] rdb_addr,
	output logic [7:0] rdb_data
);

	logic [7:0] mem_q [0:7];

	// write and core read
	always_ff @(posedge clk) begin
		if (wr_en) begin
			mem_q[wr_addr] <= wr_data;
		end
		rda_data <= mem_q[rda_addr];
	end

	// serial read; contents are static while a frame reads them
	always_ff @(posedge rd_clk) begin
		rdb_data <= mem_q[rdb_addr];
	end

endmodule // pfl_pw_store

`default_nettype wire

// ===== src/pfl_lock_cmd.sv
// Summary of operation
// - lock read shifts out lock register, repeating every eight clocks
// - lock clear zeroes the lock register, only with write enable latch set
// - lock clear runs on chip-select rise after 8 bits; busy, then latch clears
// - password read ignored once password mode is selected
// - password read: low byte first, msb first, falling edges, repeats every 64
// - password program needs the write enable latch set
// - password program ignored once password mode is selected
// - password program takes exactly 64 data bits, low byte first
// - program busy sets progress flag, failure sets error, latch clears at end
// - unlock takes exactly 64 data bits then runs a timed compare
// - unlock mismatch sets error flag and leaves progress stuck at one
// - after failed unlock only clear-status, soft or hardware reset recover
// - unlock match sets the lock bit to one
// - soft reset restores power-up state but keeps freeze and lock bit
// - soft reset keeps the nonvolatile protect configuration bits; the code clears the protect bits when the nonvolatile bit is set and unfrozen
// - soft reset clears block protect bits only if volatile and unfrozen; the code clears them when block_protect_nonvolatile is set and freeze is clear
// - only power-on or hardware reset clear freeze and reload lock bit
// - soft reset runs on chip-select rise, then needs a recovery time
// - eight ones leave continuous read mode and return to standby
// - bits are sampled on rising and driven on falling serial clock
`default_nettype none

module pfl_lock_cmd (
	// core clock and reset
	input wire logic clk,
	input wire logic reset,
	// serial link
	input wire logic sck,
	input wire logic cs_n,
	input wire logic si,
	output logic so,
	output logic so_oe,
	// hardware reset pin
	input wire logic hw_reset_n,
	// protection mode (advanced protection register bit 2, 0 = password mode)
	input wire logic asp_password_mode_n,
	// configuration writes from the register block
	input wire logic cfg_wr,
	input wire pfl_pkg::pfl_cfg_type cfg_wdata,
	// array and read engine
	input wire logic prog_fail,
	input wire logic cont_read_enter,
	// status
	output pfl_pkg::pfl_status_type status,
	output pfl_pkg::pfl_cfg_type cfg,
	output logic cont_read,
	output logic cmd_ready
);

	// ----------------------------------------
	// serial clock domain
	// ----------------------------------------
	logic first_q;
	logic [7:0] cnt_q;
	logic [7:0] cnt_d;
	logic over_q;
	logic over_d;
	logic [7:0] ins_q;
	logic [63:0] data_q;
	logic lock_s1_q;
	logic lock_s2_q;
	logic mode_s1_q;
	logic mode_s2_q;
	logic [7:0] pwb_rdata;

	// first edge of a frame restarts the count; nothing is cleared at the
	// chip-select rise so the core side can still read the frame afterwards
	always_ff @(posedge sck or posedge cs_n) begin
		if (cs_n) begin
			first_q <= 1'b1;
		end else begin
			first_q <= 1'b0;
		end
	end

	assign cnt_d = first_q ? 8'h01 : 8'(cnt_q + 8'h01);
	assign over_d = first_q ? 1'b0 : (over_q | (cnt_q == 8'hFF));
	wire in_instr = first_q || (!over_q && cnt_q < pfl_pkg::LEN_INSTR);

	// sample on rising edge; core levels pass two flops here as well
	always_ff @(posedge sck) begin
		cnt_q <= cnt_d;
		over_q <= over_d;
		lock_s1_q <= status.lock_bit;
		lock_s2_q <= lock_s1_q;
		mode_s1_q <= asp_password_mode_n;
		mode_s2_q <= mode_s1_q;
		if (in_instr) begin
			ins_q <= {ins_q[6:0], si};
		end else begin
			data_q <= {data_q[62:0], si};
		end
	end

	// output selection; byte index lags one byte behind the instruction
	wire [2:0] rdb_addr = 3'(cnt_d[5:3] - 3'h1);
	wire [2:0] bit_sel = ~cnt_q[2:0];
	wire past_instr = over_q || cnt_q >= pfl_pkg::LEN_INSTR;
	wire lock_rd = ins_q == pfl_pkg::CMD_LOCK_READ;
	wire pw_rd = ins_q == pfl_pkg::CMD_PW_READ && mode_s2_q;
	wire [7:0] lock_byte = {7'h00, lock_s2_q};
	wire rd_active = past_instr && (lock_rd || pw_rd);
	wire so_bit = pw_rd ? pwb_rdata[bit_sel] : lock_byte[bit_sel];

	// drive on falling edge; released as soon as chip select rises
	always_ff @(negedge sck or posedge cs_n) begin
		if (cs_n) begin
			so <= 1'b0;
			so_oe <= 1'b0;
		end else begin
			so <= so_bit;
			so_oe <= rd_active;
		end
	end

	// ----------------------------------------
	// frame end detection in core domain
	// ----------------------------------------
	logic cs_s1_q;
	logic cs_s2_q;
	logic cs_s3_q;
	logic hwr_s1_q;
	logic hwr_s2_q;

	// chip select and reset pin through two flops; third flop for the edge
	always_ff @(posedge clk) begin
		if (reset) begin
			cs_s1_q <= 1'b1;
			cs_s2_q <= 1'b1;
			cs_s3_q <= 1'b1;
			hwr_s1_q <= 1'b1;
			hwr_s2_q <= 1'b1;
		end else begin
			cs_s1_q <= cs_n;
			cs_s2_q <= cs_s1_q;
			cs_s3_q <= cs_s2_q;
			hwr_s1_q <= hw_reset_n;
			hwr_s2_q <= hwr_s1_q;
		end
	end

	// the serial side is frozen while chip select is high, so its frame
	// registers are read here without further synchronisation
	wire frame_end = cs_s2_q && !cs_s3_q;
	wire hw_reset = !hwr_s2_q;
	wire len_instr = !over_q && cnt_q == pfl_pkg::LEN_INSTR;
	wire len_pw = !over_q && cnt_q == pfl_pkg::LEN_INSTR_PW;
	wire f_write_enable_cmd = frame_end && len_instr && ins_q == pfl_pkg::CMD_WRITE_ENABLE;
	wire f_clear_status_cmd = frame_end && len_instr && ins_q == pfl_pkg::CMD_CLEAR_STATUS;
	wire f_lclr = frame_end && len_instr && ins_q == pfl_pkg::CMD_LOCK_CLEAR;
	wire f_soft = frame_end && len_instr && ins_q == pfl_pkg::CMD_SOFT_RESET;
	wire f_mbr = frame_end && len_instr && ins_q == pfl_pkg::CMD_MODE_BIT_RESET;
	wire f_prog = frame_end && len_pw && ins_q == pfl_pkg::CMD_PW_PROGRAM;
	wire f_unlk = frame_end && len_pw && ins_q == pfl_pkg::CMD_PW_UNLOCK;

	// ----------------------------------------
	// command sequencer
	// ----------------------------------------
	typedef enum {ST_IDLE, ST_PROG, ST_CMP, ST_OP, ST_STUCK, ST_RECOVER} pfl_state_type;

	pfl_state_type state_q;
	pfl_state_type state_d;
	pfl_pkg::pfl_op_type op_q;
	pfl_pkg::pfl_op_type op_d;
	pfl_pkg::pfl_status_type status_q;
	pfl_pkg::pfl_status_type status_d;
	pfl_pkg::pfl_cfg_type cfg_q;
	pfl_pkg::pfl_cfg_type cfg_d;
	logic [63:0] pw_q;
	logic [3:0] idx_q;
	logic [3:0] idx_d;
	logic [11:0] tmr_q;
	logic [11:0] tmr_d;
	logic miss_q;
	logic miss_d;
	logic cont_q;
	logic cont_d;
	logic [7:0] rda_data;

	// password byte n sits n bytes below the high end of the shifted stream
	wire [2:0] cur_idx = idx_q[2:0];
	wire [2:0] prev_idx = 3'(idx_q - 4'h1);
	wire [7:0] wr_byte = pw_q[{~cur_idx, 3'b000} +: 8];
	wire [7:0] cmp_byte = pw_q[{~prev_idx, 3'b000} +: 8];
	wire mem_wr = state_q == ST_PROG;
	wire tmr_done = tmr_q == 12'h000;
	wire idle_ok = state_q == ST_IDLE && !cont_q;

	// next state and flags
	always_comb begin
		state_d = state_q;
		op_d = op_q;
		status_d = status_q;
		cfg_d = cfg_q;
		idx_d = idx_q;
		miss_d = miss_q;
		cont_d = cont_q | cont_read_enter;
		tmr_d = tmr_done ? 12'h000 : 12'(tmr_q - 12'h001);
		if (cfg_wr) begin
			cfg_d = cfg_wdata;
			cfg_d.freeze = cfg_q.freeze | cfg_wdata.freeze;
		end
		case (state_q)
			ST_IDLE: begin
				if (cont_q) begin
					if (f_mbr) begin
						cont_d = 1'b0;
					end
				end else if (f_write_enable_cmd) begin
					status_d.write_enable_latch = 1'b1;
				end else if (f_clear_status_cmd) begin
					status_d.program_error = 1'b0;
				end else if (f_lclr && status_q.write_enable_latch) begin
					state_d = ST_OP;
					op_d = pfl_pkg::OP_LOCK_CLEAR;
					tmr_d = pfl_pkg::OP_CYCLES;
				end else if (f_prog && status_q.write_enable_latch && asp_password_mode_n) begin
					state_d = ST_PROG;
					idx_d = 4'h0;
				end else if (f_unlk) begin
					state_d = ST_CMP;
					idx_d = 4'h0;
					miss_d = 1'b0;
				end else if (f_soft) begin
					state_d = ST_RECOVER;
				end
			end
			ST_PROG: begin
				idx_d = 4'(idx_q + 4'h1);
				if (cur_idx == 3'h7) begin
					state_d = ST_OP;
					op_d = pfl_pkg::OP_PROGRAM;
					tmr_d = pfl_pkg::OP_CYCLES;
				end
			end
			ST_CMP: begin
				idx_d = 4'(idx_q + 4'h1);
				if (idx_q != 4'h0 && rda_data != cmp_byte) begin
					miss_d = 1'b1;
				end
				if (idx_q == 4'h8) begin
					state_d = ST_OP;
					op_d = pfl_pkg::OP_UNLOCK;
					tmr_d = pfl_pkg::OP_CYCLES;
				end
			end
			ST_OP: begin
				if (tmr_done) begin
					state_d = ST_IDLE;
					case (op_q)
						pfl_pkg::OP_LOCK_CLEAR: begin
							status_d.lock_bit = 1'b0;
							status_d.write_enable_latch = 1'b0;
						end
						pfl_pkg::OP_PROGRAM: begin
							status_d.program_error = prog_fail;
							status_d.write_enable_latch = 1'b0;
						end
						pfl_pkg::OP_UNLOCK: begin
							if (miss_q) begin
								status_d.program_error = 1'b1;
								state_d = ST_STUCK;
							end else begin
								status_d.lock_bit = 1'b1;
							end
						end
						default: begin
							state_d = ST_IDLE;
						end
					endcase
				end
			end
			ST_STUCK: begin
				// only these two frames are heard here
				if (f_clear_status_cmd) begin
					status_d.program_error = 1'b0;
					state_d = ST_IDLE;
				end else if (f_soft) begin
					state_d = ST_RECOVER;
				end
			end
			ST_RECOVER: begin
				if (tmr_done) begin
					state_d = ST_IDLE;
				end
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
		// soft reset entry: power-up flags, freeze and lock bit untouched
		if (state_d == ST_RECOVER && state_q != ST_RECOVER) begin
			tmr_d = pfl_pkg::RECOVERY_CYCLES;
			status_d.write_enable_latch = 1'b0;
			status_d.program_error = 1'b0;
			cont_d = 1'b0;
			// protect bits are cleared only when the nonvolatile bit is set and freeze is clear
			if (cfg_q.block_protect_nonvolatile && !cfg_q.freeze) begin
				{cfg_d.block_protect_bit2, cfg_d.block_protect_bit1,
					cfg_d.block_protect_bit0} = pfl_pkg::BP_CLEARED;
			end
		end
		// progress flag mirrors the program, compare, timed operation and stuck states; recovery leaves it low
		status_d.write_in_progress = state_d == ST_PROG || state_d == ST_CMP ||
			state_d == ST_OP || state_d == ST_STUCK;
	end

	// power-on and hardware reset reload the lock from the protection mode
	always_ff @(posedge clk) begin
		if (reset || hw_reset) begin
			state_q <= ST_IDLE;
			op_q <= pfl_pkg::OP_LOCK_CLEAR;
			status_q <= '0;
			status_q.lock_bit <= asp_password_mode_n;
			cfg_q <= pfl_pkg::CFG_RESET;
			idx_q <= 4'h0;
			tmr_q <= 12'h000;
			miss_q <= 1'b0;
			cont_q <= 1'b0;
		end else begin
			state_q <= state_d;
			op_q <= op_d;
			status_q <= status_d;
			cfg_q <= cfg_d;
			idx_q <= idx_d;
			tmr_q <= tmr_d;
			miss_q <= miss_d;
			cont_q <= cont_d;
		end
	end

	// payload copied at frame end while the serial side stands still
	always_ff @(posedge clk) begin
		if (reset) begin
			pw_q <= 64'h0000_0000_0000_0000;
			cmd_ready <= 1'b0;
		end else begin
			cmd_ready <= state_d == ST_IDLE;
			if (frame_end && len_pw && idle_ok) begin
				pw_q <= data_q;
			end
		end
	end

	assign status = status_q;
	assign cfg = cfg_q;
	assign cont_read = cont_q;

	// ----------------------------------------
	// password storage
	// ----------------------------------------
	pfl_pw_store u_store (
		.clk(clk),
		.wr_en(mem_wr),
		.wr_addr(cur_idx),
		.wr_data(wr_byte),
		.rda_addr(cur_idx),
		.rda_data(rda_data),
		.rd_clk(sck),
		.rdb_addr(rdb_addr),
		.rdb_data(pwb_rdata)
	);

endmodule // pfl_lock_cmd

`default_nettype wire

// ===== verif/pfl_lock_cmd_properties.sv
`default_nettype none

// ----------------------------------------
// sequencer checker
// ----------------------------------------
module pfl_lock_cmd_checker (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// watched pins
	input wire logic cs_n,
	input wire logic hw_reset_n,
	input wire logic cfg_wr,
	input wire logic so_oe,
	input wire logic cmd_ready,
	input wire pfl_pkg::pfl_status_type status,
	input wire pfl_pkg::pfl_cfg_type cfg
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);

	logic [3:0] hw_hist_q;
	logic [11:0] busy_cnt_q;
	logic hw_calm;

	// pin reset acts late through its synchroniser, so keep a short history
	always_ff @(posedge clk) begin
		if (reset) begin
			hw_hist_q <= 4'hf;
			busy_cnt_q <= 12'h000;
		end else begin
			hw_hist_q <= {hw_hist_q[2:0], hw_reset_n};
			busy_cnt_q <= status.write_in_progress ? busy_cnt_q + 12'h001 : 12'h000;
		end
	end
	assign hw_calm = hw_reset_n && (&hw_hist_q);

	// timing and ordering relations
	busy_not_ready_a: assert property (status.write_in_progress |-> !cmd_ready)
		else $error("ready while busy");
	so_quiet_a: assert property (cs_n |-> !so_oe)
		else $error("output enabled outside frame");
	lock_fall_a: assert property ($fell(status.lock_bit) && hw_calm
		|-> $fell(status.write_enable_latch) && $fell(status.write_in_progress))
		else $error("lock dropped outside a clear");
	wip_rise_a: assert property ($rose(status.write_in_progress)
		|-> $past(cs_n, 1) && $past(cs_n, 3))
		else $error("busy began inside a frame");
	wip_span_a: assert property ($fell(status.write_in_progress)
		|-> busy_cnt_q >= 12'h0c7)
		else $error("operation too short");
	stuck_hold_a: assert property (status.program_error && status.write_in_progress
		&& !cs_n && hw_calm |=> status.write_in_progress)
		else $error("stuck state left early");
	wel_set_a: assert property ($rose(status.write_enable_latch)
		|-> $past(cmd_ready) && $past(cs_n, 3))
		else $error("latch set without command");
	freeze_keep_a: assert property ($fell(cfg.freeze) |-> !hw_calm)
		else $error("freeze cleared without reset");
	nv_keep_a: assert property ($changed(cfg.block_protect_nonvolatile) && hw_calm
		|-> $past(cfg_wr))
		else $error("nonvolatile bit changed");
endmodule // pfl_lock_cmd_checker

`default_nettype wire

// ===== verif/pfl_host_model.sv
`default_nettype none

// ----------------------------------------
// serial host
// ----------------------------------------
module pfl_host_model (
	// serial link
	output logic sck,
	output logic cs_n,
	output logic si,
	input wire logic so
);
	timeunit 1ns;
	timeprecision 100ps;

	// clock idles low between frames, mode 0
	initial begin
		sck = 1'b0;
		cs_n = 1'b1;
		si = 1'b0;
	end

	// one frame, bits taken from the top of d; chip select rises right after bit n
	task automatic frame(input logic [143:0] d, input int n, output logic [143:0] r);
		r = '0;
		cs_n = 1'b0;
		#40;
		for (int i = 0; i < n; i++) begin
			si = d[143 - i];
			#31.25 sck = 1'b1;
			r = {r[142:0], so};
			#62.5 sck = 1'b0;
			#31.25;
		end
		cs_n = 1'b1;
		si = ~si; // released line must not look held
		#300;
	endtask
endmodule // pfl_host_model

`default_nettype wire

// ===== verif/pfl_lock_cmd_test.sv
`default_nettype none

// ----------------------------------------
// sequencer bench
// ----------------------------------------
module pfl_lock_cmd_test;
	timeunit 1ns;
	timeprecision 100ps;

	logic clk, reset, sck, cs_n, si, so, so_oe, hw_reset_n, asp_password_mode_n;
	logic cfg_wr, prog_fail, cont_read_enter, cont_read, cmd_ready, saw_oe;
	pfl_pkg::pfl_cfg_type cfg_wdata, cfg;
	pfl_pkg::pfl_status_type status;
	int n_errors, checked;
	logic [143:0] rx;
	logic [63:0] pw;

	pfl_lock_cmd DUT (.clk(clk), .reset(reset), .sck(sck), .cs_n(cs_n), .si(si), .so(so),
		.so_oe(so_oe), .hw_reset_n(hw_reset_n), .asp_password_mode_n(asp_password_mode_n),
		.cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata), .prog_fail(prog_fail),
		.cont_read_enter(cont_read_enter), .status(status), .cfg(cfg),
		.cont_read(cont_read), .cmd_ready(cmd_ready));
	pfl_host_model host (.sck(sck), .cs_n(cs_n), .si(si), .so(so));

	// core clock and read-enable monitor
	always #5 clk = ~clk;
	always @(posedge so_oe) saw_oe = 1'b1;

	task automatic chk(input string what, input logic [127:0] e, input logic [127:0] g);
		checked++;
		if (g !== e) begin
			$display("MISMATCH %s expected %h seen %h", what, e, g);
			n_errors++;
		end
	endtask

	task automatic chk_st(input logic [3:0] e);
		chk("status", 128'(e), 128'(status));
	endtask

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask

	// bounded wait for an idle sequencer
	task automatic wait_idle();
		int k;
		k = 0;
		repeat (5) @(negedge clk);
		while (k < 3000 && (cmd_ready !== 1'b1 || status.write_in_progress !== 1'b0)) begin
			@(negedge clk);
			k++;
		end
		if (k == 3000) chk("idle wait", 128'h1, 128'h0);
	endtask

	task automatic cmd(input logic [7:0] c, input logic [63:0] d, input int n);
		host.frame({c, d, 72'h0}, n, rx);
		wait_idle();
	endtask

	task automatic t_lock_read(input logic e);
		host.frame({pfl_pkg::CMD_LOCK_READ, 136'h0}, 24, rx);
		chk("lock read", 128'({7'h00, e, 7'h00, e}), 128'(rx[15:0]));
	endtask

	task automatic t_lock_clear();
		cmd(pfl_pkg::CMD_LOCK_CLEAR, 64'h0, 8);
		chk_st(4'b0001);
		cmd(pfl_pkg::CMD_WRITE_ENABLE, 64'h0, 8);
		cmd(pfl_pkg::CMD_LOCK_CLEAR, 64'h0, 9);
		chk_st(4'b0101);
		host.frame({pfl_pkg::CMD_LOCK_CLEAR, 136'h0}, 8, rx);
		repeat (10) @(negedge clk);
		chk_st(4'b1101);
		wait_idle();
		chk_st(4'b0000);
		t_lock_read(1'b0);
	endtask

	task automatic t_program();
		cmd(pfl_pkg::CMD_WRITE_ENABLE, 64'h0, 8);
		cmd(pfl_pkg::CMD_PW_PROGRAM, pw, 72);
		chk_st(4'b0000);
		host.frame({pfl_pkg::CMD_PW_READ, 136'h0}, 136, rx);
		chk("password", {pw, pw}, rx[127:0]);
		prog_fail = 1'b1;
		cmd(pfl_pkg::CMD_WRITE_ENABLE, 64'h0, 8);
		cmd(pfl_pkg::CMD_PW_PROGRAM, pw, 72);
		chk_st(4'b0010);
		prog_fail = 1'b0;
		cmd(pfl_pkg::CMD_CLEAR_STATUS, 64'h0, 8);
		chk_st(4'b0000);
	endtask

	task automatic t_unlock();
		host.frame({pfl_pkg::CMD_PW_UNLOCK, ~pw, 72'h0}, 72, rx);
		repeat (300) @(negedge clk);
		chk_st(4'b1010);
		chk("ready", 128'h0, 128'(cmd_ready));
		cmd(pfl_pkg::CMD_CLEAR_STATUS, 64'h0, 8);
		chk_st(4'b0000);
		cmd(pfl_pkg::CMD_PW_UNLOCK, pw, 72);
		chk_st(4'b0001);
	endtask

	task automatic load_cfg(input logic [6:0] v);
		cfg_wdata = v;
		cfg_wr = 1'b1;
		@(negedge clk);
		cfg_wr = 1'b0;
	endtask

	task automatic t_soft_reset();
		load_cfg(7'h57);
		cmd(pfl_pkg::CMD_WRITE_ENABLE, 64'h0, 8);
		host.frame({pfl_pkg::CMD_SOFT_RESET, 136'h0}, 8, rx);
		repeat (900) @(negedge clk);
		chk("ready", 128'h0, 128'(cmd_ready));
		wait_idle();
		chk("cfg", 128'h50, 128'(cfg));
		chk_st(4'b0001);
		load_cfg(7'h5f);
		cmd(pfl_pkg::CMD_SOFT_RESET, 64'h0, 8);
		chk("cfg", 128'h5f, 128'(cfg));
	endtask

	task automatic t_hw_reset();
		asp_password_mode_n = 1'b0;
		hw_reset_n = 1'b0;
		repeat (5) @(negedge clk);
		hw_reset_n = 1'b1;
		wait_idle();
		chk("cfg", 128'h0, 128'(cfg));
		chk_st(4'b0000);
	endtask

	task automatic t_pw_mode();
		saw_oe = 1'b0;
		host.frame({pfl_pkg::CMD_PW_READ, 136'h0}, 136, rx);
		chk("read enable", 128'h0, 128'(saw_oe));
		cmd(pfl_pkg::CMD_WRITE_ENABLE, 64'h0, 8);
		cmd(pfl_pkg::CMD_PW_PROGRAM, ~pw, 72);
		chk_st(4'b0100);
	endtask

	task automatic t_cont_read();
		cont_read_enter = 1'b1;
		@(negedge clk);
		cont_read_enter = 1'b0;
		cmd(pfl_pkg::CMD_LOCK_CLEAR, 64'h0, 8);
		chk_st(4'b0100);
		chk("cont read", 128'h1, 128'(cont_read));
		cmd(pfl_pkg::CMD_MODE_BIT_RESET, 64'h0, 8);
		chk("cont read", 128'h0, 128'(cont_read));
	endtask

	// main sequence, inputs move on falling edges
	initial begin
		clk = 1'b0;
		reset = 1'b1;
		hw_reset_n = 1'b1;
		asp_password_mode_n = 1'b1;
		cfg_wr = 1'b0;
		cfg_wdata = 7'h00;
		prog_fail = 1'b0;
		cont_read_enter = 1'b0;
		saw_oe = 1'b0;
		n_errors = 0;
		checked = 0;
		pw = 64'h0123_4567_89ab_cdef;
		repeat (4) @(negedge clk);
		reset = 1'b0;
		repeat (4) @(negedge clk);
		chk_st(4'b0001);
		t_lock_read(1'b1);
		t_lock_clear();
		t_program();
		t_unlock();
		t_soft_reset();
		t_hw_reset();
		t_pw_mode();
		t_cont_read();
		print_verdict();
	end

	// hang guard, far beyond the expected run
	initial begin
		#400000;
		n_errors++;
		print_verdict();
	end
endmodule // pfl_lock_cmd_test

bind pfl_lock_cmd pfl_lock_cmd_checker u_checker (.clk(clk), .reset(reset), .cs_n(cs_n),
	.hw_reset_n(hw_reset_n), .cfg_wr(cfg_wr), .so_oe(so_oe), .cmd_ready(cmd_ready),
	.status(status), .cfg(cfg));

`default_nettype wire
